// [diag_monitor_defs.vh]
// Purpose: Constants for the diagnostic monitor block
// Assumes: core_clk at 25 MHz
// Notes: Times are kept in their own unit, cycle counts derived from them
`ifndef DIAG_MONITOR_DEFS_VH
`define DIAG_MONITOR_DEFS_VH
`define CLK_MHZ 25
`define KEY_CAL_REFRESH 16'hfcba
`define KEY_LOCK 16'h4765
`define KEY_UNLOCK1 16'h896d
`define KEY_UNLOCK2 16'h57ab
`define KEY_BG_CRC 16'h7b3f
`define HALT_SIGNATURE 24'h07dead
`define TICK_DIV 14'd10000
`define BG_CRC_TIME_NS 6000
`define BG_CRC_CYCLES ((`BG_CRC_TIME_NS * `CLK_MHZ) / 1000)
`define CAL_REFRESH_CYCLES 64
`define CAP_TEST_TIME_US 100
`define CAP_TEST_CYCLES (`CAP_TEST_TIME_US * `CLK_MHZ)
`define CAP_SETTLE_CYCLES 16
`define BG_MODE_KEY 2'd0
`define BG_MODE_FRAME 2'd1
`define BG_MODE_CONT 2'd2
`define CAL_CRC_INIT 16'hffff
`define CAL_CRC_POLY 16'h1021
`define DFLAG_W 6
`define DF_CAL_CRC 0
`define DF_INVALID 1
`define DF_BG_CRC 2
`define DF_OSC_STOP 3
`define DF_UNREFRESHED 4
`define DF_SLEW_BUSY 5
`define AFLAG_W 7
`define AF_MAIN_TEMP 0
`define AF_DCDC_TEMP 1
`define AF_REF_INPUT_NODE 2
`define AF_REF_OUTPUT_NODE 3
`define AF_LDO 4
`define AF_AVCC 5
`define AF_CAP 6
`endif

// [diagnostic_monitor_logic.v]
// Purpose: Digital diagnostics: calibration CRC, background CRC, oscillator
//          tick counter, regulator capacitor test, sticky result flags
// Assumes: Analog comparator outputs arrive asynchronously; SPI decode is
//          done elsewhere and gives one-cycle strobes on core_clk
// Notes: Oscillator-stop signature is selected here; a stopped clock cannot
//        run this logic, so the halt indication comes in as a pin
`timescale 1ns/10ps
`include "diag_monitor_defs.vh"

// Operation
// - Refresh starts on refresh key or on any change of the range field.
// - Each refresh computes shadow CRC, sets error flag on reference mismatch.
// - Calibration CRC check enabled after reset, suppressed by clearing enable.
// - During refresh, writes other than readback select or nop flag invalid access.
// - Background CRC runs only while locked; unlocked requests are ignored.
// - On locking, CRC over calibration plus configuration becomes the reference.
// - One background CRC takes about 6 microseconds.
// - Background trigger: key write default, after each valid frame, or continuous.
// - 16-bit tick counter increments at oscillator over 10000, enabled after reset.
// - Halted oscillator sends 0x07dead on serial output when enabled (default).
// - Capacitor test start drives regulator to 2.7 V; fast rise flags missing cap.
// - Capacitor test start bit reads 1 during test, self-clears at its end.
// - Result flags sticky; writing 1 reloads the flag with the live condition.
// - Refresh-pending and slew-busy flags clear by themselves, not by writes.
// - Summary bits: OR of analog flags, OR of digital flags except slew-busy.
// - Temperature comparators always on, four trip settings, set flag and fault.
// - Supply comparators off after reset, enabled by general settings two bits.
// - Reference-input comparator valid only when internal enable bit is set.
// - Each monitored node has its own flag set when leaving its window.
// - Reference-output fault may also set supply, regulator and temperature flags; here it sets only its own flag.
module diagnostic_monitor_logic (
    input wire core_clk,
    input wire arst_n,
    input wire key_write,
    input wire [15:0] key_data,
    input wire reg_write,
    input wire readback_or_nop_write,
    input wire frame_valid,
    input wire [3:0] range_field,
    input wire [15:0] cal_shadow_word,
    input wire [15:0] cal_reference_crc,
    input wire [15:0] config_word,
    input wire calib_crc_enable,
    input wire tick_counter_enable,
    input wire halted_osc_signature_enable,
    input wire [1:0] bg_crc_mode,
    input wire bg_crc_enable,
    input wire regulator_cap_test_request,
    input wire [1:0] temp_trip_select,
    input wire [1:0] supply_comparator_enable,
    input wire internal_enable,
    input wire osc_halted,
    input wire slew_active,
    input wire main_temp_over,
    input wire dcdc_temp_over,
    input wire ref_input_node_bad,
    input wire ref_output_node_bad,
    input wire regulator_output_node_bad,
    input wire internal_analog_supply_bad,
    input wire regulator_at_target,
    input wire [`DFLAG_W-1:0] digital_clear_ones,
    input wire [`AFLAG_W-1:0] analog_clear_ones,
    output reg [`DFLAG_W-1:0] digital_result_flags,
    output reg [`AFLAG_W-1:0] analog_result_flags,
    output wire digital_flags_summary,
    output wire analog_flags_summary,
    output reg [15:0] oscillator_tick_counter,
    output wire regulator_cap_test_start,
    output reg regulator_drive_low_target,
    output reg calib_refresh_busy,
    output reg [5:0] cal_shadow_addr,
    output reg config_locked,
    output reg [15:0] bg_crc_reference,
    output reg [1:0] temp_trip_level,
    output reg [23:0] sdo_override_word,
    output wire sdo_override_enable,
    output wire fault_n
);

    // Synchronise every asynchronous analog or pin level
    localparam NSYNC = 9;
    wire [NSYNC-1:0] async_in = {osc_halted, main_temp_over, dcdc_temp_over,
        ref_input_node_bad, ref_output_node_bad, regulator_output_node_bad,
        internal_analog_supply_bad, regulator_at_target, slew_active};
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= {NSYNC{1'b0}};
            sync2_reg <= {NSYNC{1'b0}};
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire halt_s = sync2_reg[8];
    wire main_temp_s = sync2_reg[7];
    wire dcdc_temp_s = sync2_reg[6];
    wire ref_input_node_s = sync2_reg[5];
    wire ref_output_node_s = sync2_reg[4];
    wire ldo_s = sync2_reg[3];
    wire avcc_s = sync2_reg[2];
    wire at_target_s = sync2_reg[1];
    wire slew_s = sync2_reg[0];

    // CRC-16 step shared by both checks
    function [15:0] crc_step;
        input [15:0] crc;
        input [15:0] data;
        integer i;
        reg [15:0] c;
        begin
            c = crc ^ data;
            for (i = 0; i < 16; i = i + 1) begin
                c = c[15] ? ((c << 1) ^ `CAL_CRC_POLY) : (c << 1);
            end
            crc_step = c;
        end
    endfunction

    // Calibration refresh walks the shadow words, then compares the CRC
    reg [3:0] range_prev_reg;
    reg [15:0] cal_crc_reg;
    reg cal_done_pulse;
    reg cal_mismatch;
    // The first edge after reset only captures the range, so a nonzero
    // setting at power-up is not mistaken for a change
    reg range_valid_reg;
    wire refresh_start = (key_write && key_data == `KEY_CAL_REFRESH) ||
                         (range_valid_reg && range_field != range_prev_reg);
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            range_prev_reg <= 4'h0;
            range_valid_reg <= 1'b0;
            calib_refresh_busy <= 1'b0;
            cal_shadow_addr <= 6'h00;
            cal_crc_reg <= `CAL_CRC_INIT;
            cal_done_pulse <= 1'b0;
            cal_mismatch <= 1'b0;
        end else begin
            range_prev_reg <= range_field;
            range_valid_reg <= 1'b1;
            cal_done_pulse <= 1'b0;
            if (refresh_start && !calib_refresh_busy) begin
                calib_refresh_busy <= 1'b1;
                cal_shadow_addr <= 6'h00;
                cal_crc_reg <= `CAL_CRC_INIT;
            end else if (calib_refresh_busy) begin
                cal_crc_reg <= crc_step(cal_crc_reg, cal_shadow_word);
                cal_shadow_addr <= cal_shadow_addr + 6'h01;
                if (cal_shadow_addr == `CAL_REFRESH_CYCLES - 1) begin
                    calib_refresh_busy <= 1'b0;
                    cal_done_pulse <= 1'b1;
                    cal_mismatch <= crc_step(cal_crc_reg, cal_shadow_word) !=
                                    cal_reference_crc;
                end
            end
        end
    end

    // Lock state follows the key sequence
    reg unlock_armed_reg;
    reg lock_crc_pending_reg;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_locked <= 1'b0;
            unlock_armed_reg <= 1'b0;
        end else if (key_write) begin
            unlock_armed_reg <= (key_data == `KEY_UNLOCK1);
            if (key_data == `KEY_LOCK) begin
                config_locked <= 1'b1;
            end else if (unlock_armed_reg && key_data == `KEY_UNLOCK2) begin
                config_locked <= 1'b0;
            end
        end
    end

    // Background CRC engine; the first run after locking sets the reference
    localparam BG_IDLE = 1'b0;
    localparam BG_RUN = 1'b1;
    reg bg_state_reg;
    reg [7:0] bg_count_reg;
    reg [15:0] bg_crc_reg;
    reg bg_error_pulse;
    wire lock_rise = key_write && key_data == `KEY_LOCK && !config_locked;
    reg bg_trigger;
    always @* begin
        case (bg_crc_mode)
            `BG_MODE_KEY: bg_trigger = key_write && key_data == `KEY_BG_CRC;
            `BG_MODE_FRAME: bg_trigger = frame_valid;
            `BG_MODE_CONT: bg_trigger = bg_crc_enable;
            default: bg_trigger = 1'b0;
        endcase
    end
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bg_state_reg <= BG_IDLE;
            bg_count_reg <= 8'h00;
            bg_crc_reg <= `CAL_CRC_INIT;
            bg_crc_reference <= 16'h0000;
            lock_crc_pending_reg <= 1'b0;
            bg_error_pulse <= 1'b0;
        end else begin
            bg_error_pulse <= 1'b0;
            if (lock_rise) begin
                lock_crc_pending_reg <= 1'b1;
            end
            case (bg_state_reg)
                BG_IDLE: begin
                    if (config_locked && (lock_crc_pending_reg || bg_trigger)) begin
                        bg_state_reg <= BG_RUN;
                        bg_count_reg <= 8'h00;
                        bg_crc_reg <= `CAL_CRC_INIT;
                    end
                end
                BG_RUN: begin
                    bg_crc_reg <= crc_step(bg_crc_reg, config_word ^ cal_shadow_word);
                    bg_count_reg <= bg_count_reg + 8'h01;
                    if (!config_locked) begin
                        bg_state_reg <= BG_IDLE;
                    end else if (bg_count_reg == `BG_CRC_CYCLES - 1) begin
                        bg_state_reg <= BG_IDLE;
                        if (lock_crc_pending_reg) begin
                            bg_crc_reference <= bg_crc_reg;
                            lock_crc_pending_reg <= 1'b0;
                        end else begin
                            bg_error_pulse <= bg_crc_reg != bg_crc_reference;
                        end
                    end
                end
                default: bg_state_reg <= BG_IDLE;
            endcase
        end
    end

    // Divide the clock by 10000 to form the tick enable
    reg [13:0] div_reg;
    wire tick = div_reg == `TICK_DIV - 14'd1;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 14'd0;
            oscillator_tick_counter <= 16'h0000;
        end else if (tick_counter_enable) begin
            div_reg <= tick ? 14'd0 : div_reg + 14'd1;
            if (tick) begin
                oscillator_tick_counter <= oscillator_tick_counter + 16'h0001;
            end
        end
    end

    // Capacitor test: time the regulator rise toward its low target
    localparam CAP_IDLE = 2'd0;
    localparam CAP_RISE = 2'd1;
    localparam CAP_SETTLE = 2'd2;
    reg [1:0] cap_state_reg;
    reg [11:0] cap_count_reg;
    reg cap_missing_pulse;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_state_reg <= CAP_IDLE;
            cap_count_reg <= 12'h000;
            regulator_drive_low_target <= 1'b0;
            cap_missing_pulse <= 1'b0;
        end else begin
            cap_missing_pulse <= 1'b0;
            case (cap_state_reg)
                CAP_IDLE: begin
                    if (regulator_cap_test_request) begin
                        cap_state_reg <= CAP_RISE;
                        cap_count_reg <= 12'h000;
                        regulator_drive_low_target <= 1'b1;
                    end
                end
                CAP_RISE: begin
                    cap_count_reg <= cap_count_reg + 12'h001;
                    if (at_target_s || cap_count_reg == `CAP_TEST_CYCLES - 1) begin
                        // Fast arrival means no bulk capacitance on the pin
                        cap_missing_pulse <= at_target_s;
                        regulator_drive_low_target <= 1'b0;
                        cap_state_reg <= CAP_SETTLE;
                        cap_count_reg <= 12'h000;
                    end
                end
                CAP_SETTLE: begin
                    cap_count_reg <= cap_count_reg + 12'h001;
                    if (cap_count_reg == `CAP_SETTLE_CYCLES - 1) begin
                        cap_state_reg <= CAP_IDLE;
                    end
                end
                default: cap_state_reg <= CAP_IDLE;
            endcase
        end
    end
    assign regulator_cap_test_start = cap_state_reg != CAP_IDLE;

    // Live fault conditions feeding the sticky flags
    wire cmp_on = supply_comparator_enable != 2'b00;
    wire [`AFLAG_W-1:0] analog_live;
    assign analog_live[`AF_MAIN_TEMP] = main_temp_s;
    assign analog_live[`AF_DCDC_TEMP] = dcdc_temp_s;
    assign analog_live[`AF_REF_INPUT_NODE] = cmp_on && internal_enable && ref_input_node_s;
    // Reference-output fault sets only its own flag; no other flag is derived from it
    assign analog_live[`AF_REF_OUTPUT_NODE] = cmp_on && ref_output_node_s;
    assign analog_live[`AF_LDO] = cmp_on && ldo_s;
    assign analog_live[`AF_AVCC] = cmp_on && avcc_s;
    assign analog_live[`AF_CAP] = cap_missing_pulse;
    wire [`DFLAG_W-1:0] digital_live;
    assign digital_live[`DF_CAL_CRC] = cal_done_pulse && cal_mismatch && calib_crc_enable;
    assign digital_live[`DF_INVALID] = calib_refresh_busy && reg_write &&
                                       !readback_or_nop_write;
    assign digital_live[`DF_BG_CRC] = bg_error_pulse;
    assign digital_live[`DF_OSC_STOP] = halt_s && halted_osc_signature_enable;
    assign digital_live[`DF_UNREFRESHED] = calib_refresh_busy;
    assign digital_live[`DF_SLEW_BUSY] = slew_s;

    // Sticky flags: event set wins; writing 1 reloads the live value
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            digital_result_flags <= {`DFLAG_W{1'b0}};
            analog_result_flags <= {`AFLAG_W{1'b0}};
            temp_trip_level <= 2'd0;
        end else begin
            temp_trip_level <= temp_trip_select;
            analog_result_flags <= analog_live |
                (analog_result_flags & ~analog_clear_ones);
            digital_result_flags <= digital_live |
                (digital_result_flags & ~digital_clear_ones);
            digital_result_flags[`DF_UNREFRESHED] <= calib_refresh_busy;
            digital_result_flags[`DF_SLEW_BUSY] <= slew_s;
        end
    end

    assign digital_flags_summary = |(digital_result_flags &
        ~({{(`DFLAG_W-1){1'b0}}, 1'b1} << `DF_SLEW_BUSY));
    assign analog_flags_summary = |analog_result_flags;
    assign fault_n = !(analog_result_flags[`AF_MAIN_TEMP] ||
        analog_result_flags[`AF_DCDC_TEMP]);

    // Serial output signature while the oscillator is seen halted
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_override_word <= 24'h000000;
        end else begin
            sdo_override_word <= `HALT_SIGNATURE;
        end
    end
    assign sdo_override_enable = halt_s && halted_osc_signature_enable;

endmodule

// [diag_monitor_props.sv]
// Purpose: Port-level checks for the diagnostic monitor block
// Assumes: Single core_clk domain, arst_n held for at least one edge
// Notes: Bound into every instance of the block
`timescale 1ns/10ps
`include "diag_monitor_defs.vh"

module diag_monitor_props (
    input wire core_clk,
    input wire arst_n,
    input wire key_write,
    input wire [15:0] key_data,
    input wire reg_write,
    input wire readback_or_nop_write,
    input wire [5:0] digital_result_flags,
    input wire [6:0] analog_result_flags,
    input wire digital_flags_summary,
    input wire analog_flags_summary,
    input wire [15:0] oscillator_tick_counter,
    input wire regulator_cap_test_start,
    input wire calib_refresh_busy,
    input wire config_locked,
    input wire [23:0] sdo_override_word,
    input wire fault_n,
    input wire [5:0] digital_clear_ones
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Summaries are plain ORs; slew-busy is left out on purpose
    chk_dig_summary: assert property (digital_flags_summary == |digital_result_flags[4:0])
        else $error("digital summary wrong");
    chk_ana_summary: assert property (analog_flags_summary == |analog_result_flags)
        else $error("analog summary wrong");
    // Refresh start and its fixed length
    chk_refresh_start: assert property (key_write && key_data == `KEY_CAL_REFRESH
        && !calib_refresh_busy |=> calib_refresh_busy) else $error("refresh not started");
    chk_refresh_len: assert property ($rose(calib_refresh_busy)
        |-> ##63 calib_refresh_busy ##1 !calib_refresh_busy) else $error("refresh length wrong");
    chk_invalid_set: assert property (reg_write && !readback_or_nop_write && calib_refresh_busy
        |=> digital_result_flags[`DF_INVALID]) else $error("invalid access not flagged");
    chk_lock_key: assert property (key_write && key_data == `KEY_LOCK |=> config_locked)
        else $error("lock key ignored");
    // Counter only ever steps by one, which also covers the wrap
    chk_tick_step: assert property ($changed(oscillator_tick_counter)
        |-> oscillator_tick_counter == $past(oscillator_tick_counter) + 16'h0001)
        else $error("tick counter jumped");
    chk_cap_hold: assert property ($rose(regulator_cap_test_start)
        |-> regulator_cap_test_start [*8]) else $error("cap test start dropped early");
    chk_temp_fault: assert property (analog_result_flags[`AF_MAIN_TEMP]
        || analog_result_flags[`AF_DCDC_TEMP] |-> !fault_n) else $error("fault pin not low");
    chk_halt_code: assert property ($past(arst_n) |-> sdo_override_word == `HALT_SIGNATURE)
        else $error("halt signature wrong");
    // A sticky flag may only drop right after a write-one
    chk_sticky_cal: assert property ($fell(digital_result_flags[`DF_CAL_CRC])
        |-> $past(digital_clear_ones[`DF_CAL_CRC])) else $error("sticky flag dropped");
endmodule

bind diagnostic_monitor_logic diag_monitor_props diag_monitor_props_i (.*);

// [diag_far_side_model.sv]
// Purpose: Shadow memory and regulator seen from the block
// Assumes: rise_cycles of 0 means the regulator never reaches target
// Notes: Shadow content is a fixed pattern of the address
`timescale 1ns/10ps

module diag_far_side_model (
    input wire core_clk,
    input wire arst_n,
    input wire [5:0] cal_shadow_addr,
    output wire [15:0] cal_shadow_word,
    input wire regulator_cap_test_start,
    input wire [31:0] rise_cycles,
    output reg regulator_at_target
);
    integer count;

    // Combinational read, every word differs so a skipped address shows
    assign cal_shadow_word = {~cal_shadow_addr, 4'ha, cal_shadow_addr};

    // Regulator reaches target after rise_cycles of drive, low when idle
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n || !regulator_cap_test_start) begin
            count <= 0;
            regulator_at_target <= 1'b0;
        end else begin
            count <= count + 1;
            if (rise_cycles != 0 && count >= rise_cycles) regulator_at_target <= 1'b1;
        end
    end
endmodule

// [diagnostic_monitor_logic_tb_top.sv]
// Purpose: Directed tests of the diagnostic monitor block
// Assumes: Inputs change at the falling edge, outputs read there too
// Notes: Run resets the block before each background CRC mode
`timescale 1ns/10ps

module diagnostic_monitor_logic_tb_top;
    reg core_clk = 1'b0, arst_n = 1'b0, key_write = 1'b0, reg_write = 1'b0, frame_valid = 1'b0;
    reg readback_or_nop_write = 1'b0, calib_crc_enable = 1'b0, tick_counter_enable = 1'b1;
    reg [15:0] key_data = 16'h0000, cal_reference_crc = 16'h0000, config_word = 16'h1234, c0;
    reg [3:0] range_field = 4'h0;
    reg [1:0] bg_crc_mode = 2'd0, temp_trip_select = 2'd0, supply_comparator_enable = 2'd0;
    reg halted_osc_signature_enable = 1'b1, bg_crc_enable = 1'b0, internal_enable = 1'b0;
    reg regulator_cap_test_request = 1'b0, osc_halted = 1'b0, slew_active = 1'b0, f0;
    reg main_temp_over = 1'b0, dcdc_temp_over = 1'b0, ref_input_node_bad = 1'b0;
    reg ref_output_node_bad = 1'b0, regulator_output_node_bad = 1'b0;
    reg internal_analog_supply_bad = 1'b0;
    reg [5:0] digital_clear_ones = 6'h00;
    reg [6:0] analog_clear_ones = 7'h00;
    integer rise_cycles = 0, n_fail = 0, n_tests = 0, m, w;
    wire [15:0] cal_shadow_word, oscillator_tick_counter, bg_crc_reference;
    wire [5:0] digital_result_flags, cal_shadow_addr;
    wire [6:0] analog_result_flags;
    wire [1:0] temp_trip_level;
    wire [23:0] sdo_override_word;
    wire regulator_at_target, digital_flags_summary, analog_flags_summary, fault_n;
    wire regulator_cap_test_start, regulator_drive_low_target, calib_refresh_busy;
    wire config_locked, sdo_override_enable;

    diagnostic_monitor_logic diagnostic_monitor_logic_i (.*);
    diag_far_side_model diag_far_side_model_i (.*);

    always #20 core_clk = ~core_clk;

    task cyc(input integer n); repeat (n) @(negedge core_clk); endtask
    task chk(input [23:0] got, input [23:0] exp); begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end endtask
    task key(input [15:0] k); begin key_write = 1'b1; key_data = k; cyc(1); key_write = 1'b0; end endtask
    task dclr(input [5:0] v); begin digital_clear_ones = v; cyc(1); digital_clear_ones = 6'h00; end endtask
    task aclr(input [6:0] v); begin analog_clear_ones = v; cyc(1); analog_clear_ones = 7'h00; end endtask
    // One background trigger in the chosen mode; continuous mode stays on
    task trig(input integer md); begin
        if (md == 0) key(16'h7b3f);
        else if (md == 1) begin frame_valid = 1'b1; cyc(1); frame_valid = 1'b0; end
        else bg_crc_enable = 1'b1;
    end endtask
    // Host stays quiet for the whole test, waiting on the start bit
    task cap_run(input integer rc, input exp); begin
        rise_cycles = rc;
        regulator_cap_test_request = 1'b1;
        cyc(1);
        regulator_cap_test_request = 1'b0;
        cyc(2);
        chk({regulator_cap_test_start, regulator_drive_low_target}, 2'b11);
        w = 0;
        while (regulator_cap_test_start === 1'b1 && w < 3000) begin cyc(1); w = w + 1; end
        chk({regulator_cap_test_start, regulator_drive_low_target}, 2'b00);
        chk(analog_result_flags[6], exp);
        chk(w > 2400, rc == 0);
        aclr(7'h40);
        cyc(1);
    end endtask
    task conclude; begin
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    end endtask

    // Hang guard, well beyond the roughly 37000 cycles of the run
    initial begin #2400000; n_fail = n_fail + 1; conclude; end

    initial begin
        cyc(2);
        arst_n = 1'b1;
        cyc(2);
        // Exactly one step per 10000 enabled cycles, none when disabled
        c0 = oscillator_tick_counter;
        cyc(10000);
        chk(oscillator_tick_counter, c0 + 16'h0001);
        tick_counter_enable = 1'b0;
        c0 = oscillator_tick_counter;
        cyc(10000);
        chk(oscillator_tick_counter, c0);
        tick_counter_enable = 1'b1;
        // Refresh with the check suppressed, then policed writes in a refresh
        key(16'hfcba);
        chk(calib_refresh_busy, 1'b1);
        cyc(70);
        chk(digital_result_flags[0], 1'b0);
        calib_crc_enable = 1'b1;
        key(16'hfcba);
        cyc(5);
        reg_write = 1'b1;
        readback_or_nop_write = 1'b1;
        cyc(1);
        chk(digital_result_flags[4:1], 4'b1000);
        readback_or_nop_write = 1'b0;
        cyc(1);
        reg_write = 1'b0;
        chk(digital_result_flags[1], 1'b1);
        key(16'hfcba);
        cyc(57);
        chk({calib_refresh_busy, digital_result_flags[4]}, 2'b00);
        cyc(3);
        f0 = digital_result_flags[0];
        dclr(6'h03);
        chk(digital_result_flags[1], 1'b0);
        // Two opposite references cannot both match the same content
        cal_reference_crc = 16'hffff;
        key(16'hfcba);
        cyc(70);
        chk(digital_result_flags[0] | f0, 1'b1);
        range_field = 4'h5;
        cyc(1);
        chk(calib_refresh_busy, 1'b1);
        cyc(12500);
        // Temperature flag stays while the cause stays, fault pin follows
        main_temp_over = 1'b1;
        cyc(6);
        chk({analog_result_flags[0], fault_n}, 2'b10);
        aclr(7'h01);
        cyc(1);
        chk(analog_result_flags[0], 1'b1);
        main_temp_over = 1'b0;
        cyc(6);
        chk(analog_result_flags[0], 1'b1);
        aclr(7'h01);
        chk({analog_result_flags[0], fault_n}, 2'b01);
        for (m = 0; m < 4; m = m + 1) begin temp_trip_select = m; cyc(2); chk(temp_trip_level, m); end
        // Supply comparators off until enabled, ref input needs internal enable
        {ref_output_node_bad, ref_input_node_bad} = 2'b11;
        {regulator_output_node_bad, internal_analog_supply_bad, dcdc_temp_over} = 3'b111;
        cyc(6);
        chk({analog_result_flags[5:1], fault_n}, 6'b000010);
        supply_comparator_enable = 2'b01;
        cyc(6);
        chk(analog_result_flags[5:1], 5'b11101);
        internal_enable = 1'b1;
        cyc(6);
        chk(analog_result_flags[2], 1'b1);
        {ref_output_node_bad, ref_input_node_bad} = 2'b00;
        {regulator_output_node_bad, internal_analog_supply_bad, dcdc_temp_over} = 3'b000;
        cyc(6);
        aclr(7'h7f);
        chk(analog_flags_summary, 1'b0);
        slew_active = 1'b1;
        cyc(6);
        chk(digital_result_flags[5], 1'b1);
        slew_active = 1'b0;
        cyc(6);
        chk(digital_result_flags[5], 1'b0);
        osc_halted = 1'b1;
        cyc(6);
        chk(sdo_override_word, 24'h07dead);
        chk({sdo_override_enable, digital_result_flags[3]}, 2'b11);
        chk(digital_flags_summary, 1'b1);
        halted_osc_signature_enable = 1'b0;
        cyc(2);
        chk(sdo_override_enable, 1'b0);
        {osc_halted, halted_osc_signature_enable} = 2'b01;
        cap_run(100, 1'b1);
        cap_run(0, 1'b0);
        // Background CRC in each mode, from a fresh reset each time
        for (m = 0; m < 3; m = m + 1) begin
            arst_n = 1'b0;
            cyc(2);
            arst_n = 1'b1;
            config_word = 16'h1234;
            bg_crc_mode = m;
            cyc(1);
            trig(m);
            cyc(160);
            chk(digital_result_flags[2], 1'b0);
            bg_crc_enable = 1'b0;
            key(16'h4765);
            chk(config_locked, 1'b1);
            cyc(160);
            chk(digital_result_flags[2], 1'b0);
            config_word = 16'h5678;
            trig(m);
            cyc(140);
            chk(digital_result_flags[2], 1'b0);
            cyc(15);
            chk(digital_result_flags[2], 1'b1);
            bg_crc_enable = 1'b0;
            key_write = 1'b1;
            key_data = 16'h896d;
            cyc(1);
            key_data = 16'h57ab;
            cyc(1);
            key_write = 1'b0;
            chk(config_locked, 1'b0);
        end
        conclude;
    end
endmodule
